// ---- verilog/szu_pkg.sv ----
// constants, codes and carriers for serial port zero
// assumes one system clock and a byte-wide special-function register port
package szu_pkg;
	// ----------------------------------------
	// register addresses and reset values
	// ----------------------------------------
	localparam logic [7:0] SZU_ADDR_CONTROL = 8'h98;
	localparam logic [7:0] SZU_ADDR_BUFFER = 8'h99;
	localparam logic [7:0] SZU_ADDR_POWER = 8'h87;
	localparam logic [7:0] SZU_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SZU_BUFFER_RESET = 8'h00;
	// ----------------------------------------
	// control and power register fields
	// ----------------------------------------
	localparam int SZU_BIT_MODE_HIGH = 7;
	localparam int SZU_BIT_MODE_LOW = 6;
	localparam int SZU_BIT_MP_FILTER = 5;
	localparam int SZU_BIT_RX_ENABLE = 4;
	localparam int SZU_BIT_TX_NINTH = 3;
	localparam int SZU_BIT_RX_NINTH = 2;
	localparam int SZU_BIT_TX_DONE = 1;
	localparam int SZU_BIT_RX_DONE = 0;
	localparam int SZU_BIT_DIV_SELECT = 7;
	// ----------------------------------------
	// modes and timing
	// ----------------------------------------
	localparam logic [1:0] SZU_MODE_SHIFT = 2'h0;
	localparam logic [1:0] SZU_MODE_ASYNC10 = 2'h1;
	localparam logic [1:0] SZU_MODE_ASYNC11 = 2'h3;
	localparam logic [3:0] SZU_SHIFT_DIV_SLOW = 4'hc;
	localparam logic [3:0] SZU_SHIFT_DIV_FAST = 4'h4;
	localparam int SZU_ASYNC_SLOW_SHIFT = 4;
	localparam logic [3:0] SZU_FRAME_BITS10 = 4'ha;
	localparam logic [3:0] SZU_FRAME_BITS11 = 4'hb;
	localparam logic [3:0] SZU_SHIFT_BITS = 4'h8;
	localparam int SZU_PERIOD_W = 20;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} szu_sfr_req_s;
	typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SHIFT_OUT, TX_SHIFT_IN} szu_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} szu_rx_e;
endpackage

// ---- verilog/szu_bit_timer.sv ----
// bit period timer: pulses at the middle and end of each bit period
// assumes period of at least one system clock
`timescale 1ns/1ps
`default_nettype none
module szu_bit_timer
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic restart,
	input wire logic run,
	input wire logic [szu_pkg::SZU_PERIOD_W-1:0] period,
	output logic mid_pulse,
	output logic end_pulse
);
	logic [szu_pkg::SZU_PERIOD_W-1:0] cnt_reg;
	logic [szu_pkg::SZU_PERIOD_W-1:0] cnt_next;
	logic [szu_pkg::SZU_PERIOD_W-1:0] last;

	assign last = (period == '0) ? '0 : period - 1'b1;
	assign mid_pulse = run && !restart && (cnt_reg == (period >> 1));
	assign end_pulse = run && !restart && (cnt_reg == last);

	always_comb
	begin
		cnt_next = cnt_reg;
		if (restart || !run || end_pulse)
		begin
			cnt_next = '0;
		end
		else
		begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_reg <= '0;
		end
		else if (ce)
		begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/szu_rx_async.sv ----
// asynchronous receiver for the 10-bit and 11-bit frames
// assumes rxd synchronous to sys_clk; reports a frame at mid stop bit
`timescale 1ns/1ps
`default_nettype none
module szu_rx_async
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic enable,
	input wire logic ninth_mode,
	input wire logic baud_run,
	input wire logic [szu_pkg::SZU_PERIOD_W-1:0] period,
	input wire logic rxd,
	output logic done,
	output logic [7:0] data,
	output logic ninth
);
	szu_pkg::szu_rx_e state_reg;
	szu_pkg::szu_rx_e state_next;
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic ninth_reg;
	logic ninth_next;
	logic [2:0] idx_reg;
	logic [2:0] idx_next;
	logic rxd_prev_reg;
	logic start_edge;
	logic mid;

	assign start_edge = enable && rxd_prev_reg && !rxd && state_reg == szu_pkg::RX_IDLE;

	szu_bit_timer u_timer
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.restart(start_edge),
		.run(baud_run && state_reg != szu_pkg::RX_IDLE),
		.period(period),
		.mid_pulse(mid),
		.end_pulse()
	);

	always_comb
	begin
		state_next = state_reg;
		data_next = data_reg;
		ninth_next = ninth_reg;
		idx_next = idx_reg;
		done = 1'b0;
		case (state_reg)
			szu_pkg::RX_IDLE:
			begin
				if (start_edge)
				begin
					state_next = szu_pkg::RX_START;
				end
			end
			szu_pkg::RX_START:
			begin
				// false start if line is back high at mid bit
				if (mid)
				begin
					state_next = rxd ? szu_pkg::RX_IDLE : szu_pkg::RX_DATA;
					idx_next = 3'h0;
				end
			end
			szu_pkg::RX_DATA:
			begin
				if (mid)
				begin
					data_next = {rxd, data_reg[7:1]};
					idx_next = idx_reg + 3'h1;
					if (idx_reg == 3'h7)
					begin
						state_next = ninth_mode ? szu_pkg::RX_NINTH : szu_pkg::RX_STOP;
					end
				end
			end
			szu_pkg::RX_NINTH:
			begin
				if (mid)
				begin
					ninth_next = rxd;
					state_next = szu_pkg::RX_STOP;
				end
			end
			szu_pkg::RX_STOP:
			begin
				if (mid)
				begin
					done = 1'b1;
					state_next = szu_pkg::RX_IDLE;
				end
			end
			default:
			begin
				state_next = szu_pkg::RX_IDLE;
			end
		endcase
		if (!enable)
		begin
			state_next = szu_pkg::RX_IDLE;
		end
	end

	assign data = data_reg;
	assign ninth = ninth_reg;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= szu_pkg::RX_IDLE;
			data_reg <= 8'h00;
			ninth_reg <= 1'b0;
			idx_reg <= 3'h0;
			rxd_prev_reg <= 1'b1;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			data_reg <= data_next;
			ninth_reg <= ninth_next;
			idx_reg <= idx_next;
			rxd_prev_reg <= rxd;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/szu_serial_port_zero.sv ----
// serial port zero: control and buffer registers, transmitter, shift mode
// assumes the register port and all pin inputs are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module szu_serial_port_zero
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire szu_pkg::szu_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic [15:0] timer_one_reload,
	input wire logic [15:0] timer_two_reload,
	input wire logic timer_one_run,
	input wire logic tx_timer_two_clock_select,
	input wire logic rx_timer_two_clock_select,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out,
	output logic serial_irq
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [7:0] rx_latch_reg;
	logic [7:0] rx_latch_next;
	logic div_select_reg;
	logic div_select_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic irq_reg;

	logic wr_control;
	logic wr_buffer;
	logic [1:0] mode;
	logic async_mode;
	logic ninth_mode;
	logic tx_done_set;
	logic rx_done_set;
	logic rx_load;
	logic [7:0] rx_load_data;
	logic rx_load_ninth;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	assign wr_control = sfr_req.wr && hit(sfr_req.addr, szu_pkg::SZU_ADDR_CONTROL);
	assign wr_buffer = sfr_req.wr && hit(sfr_req.addr, szu_pkg::SZU_ADDR_BUFFER);
	assign mode = {control_reg[szu_pkg::SZU_BIT_MODE_HIGH], control_reg[szu_pkg::SZU_BIT_MODE_LOW]};
	assign async_mode = (mode == szu_pkg::SZU_MODE_ASYNC10) || (mode == szu_pkg::SZU_MODE_ASYNC11);
	assign ninth_mode = (mode == szu_pkg::SZU_MODE_ASYNC11);

	// ----------------------------------------
	// baud source
	// ----------------------------------------
	logic use_timer_two;
	logic baud_run;
	logic [15:0] reload;
	logic [szu_pkg::SZU_PERIOD_W-1:0] bit_period;

	assign use_timer_two = tx_timer_two_clock_select || rx_timer_two_clock_select;
	assign baud_run = use_timer_two || !timer_one_run;
	assign reload = use_timer_two ? timer_two_reload : timer_one_reload;
	assign bit_period = div_select_reg ?
		({4'h0, reload} << szu_pkg::SZU_ASYNC_SLOW_SHIFT) : {4'h0, reload};

	// ----------------------------------------
	// async receiver
	// ----------------------------------------
	logic arx_done;
	logic [7:0] arx_data;
	logic arx_ninth;

	szu_rx_async u_rx
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.enable(async_mode && control_reg[szu_pkg::SZU_BIT_RX_ENABLE]),
		.ninth_mode(ninth_mode),
		.baud_run(baud_run),
		.period(bit_period),
		.rxd(rxd_in),
		.done(arx_done),
		.data(arx_data),
		.ninth(arx_ninth)
	);

	// ----------------------------------------
	// transmitter and shift mode
	// ----------------------------------------
	szu_pkg::szu_tx_e tx_state_reg;
	szu_pkg::szu_tx_e tx_state_next;
	logic [10:0] tx_shift_reg;
	logic [10:0] tx_shift_next;
	logic [3:0] tx_left_reg;
	logic [3:0] tx_left_next;
	logic [3:0] div_cnt_reg;
	logic [3:0] div_cnt_next;
	logic sclk_reg;
	logic sclk_next;
	logic [7:0] sin_reg;
	logic [7:0] sin_next;
	logic txd_reg;
	logic txd_next;
	logic rxd_out_reg;
	logic rxd_out_next;
	logic rxd_oe_reg;
	logic rxd_oe_next;
	logic tx_end;
	logic [3:0] half_div;
	logic sclk_tick;

	szu_bit_timer u_tx_timer
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.restart(wr_buffer && tx_state_reg == szu_pkg::TX_IDLE),
		.run(baud_run && tx_state_reg == szu_pkg::TX_ASYNC),
		.period(bit_period),
		.mid_pulse(),
		.end_pulse(tx_end)
	);

	assign half_div = (div_select_reg ? szu_pkg::SZU_SHIFT_DIV_FAST : szu_pkg::SZU_SHIFT_DIV_SLOW) >> 1;
	assign sclk_tick = (div_cnt_reg == half_div - 4'h1);

	always_comb
	begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_left_next = tx_left_reg;
		div_cnt_next = 4'h0;
		sclk_next = 1'b1;
		sin_next = sin_reg;
		txd_next = txd_reg;
		rxd_out_next = rxd_out_reg;
		rxd_oe_next = 1'b0;
		tx_done_set = 1'b0;
		rx_load = arx_done;
		rx_load_data = arx_data;
		rx_load_ninth = arx_ninth;
		case (tx_state_reg)
			szu_pkg::TX_IDLE:
			begin
				txd_next = 1'b1;
				rxd_out_next = 1'b1;
				if (wr_buffer && async_mode)
				begin
					// frame lsb first: start, data, ninth or stop, stop
					tx_shift_next = {2'b11, sfr_req.wdata, 1'b0};
					if (ninth_mode)
					begin
						tx_shift_next[9] = control_reg[szu_pkg::SZU_BIT_TX_NINTH];
					end
					tx_left_next = ninth_mode ? szu_pkg::SZU_FRAME_BITS11 : szu_pkg::SZU_FRAME_BITS10;
					txd_next = 1'b0;
					tx_state_next = szu_pkg::TX_ASYNC;
				end
				else if (wr_buffer && mode == szu_pkg::SZU_MODE_SHIFT)
				begin
					tx_shift_next = {3'b111, sfr_req.wdata};
					tx_left_next = szu_pkg::SZU_SHIFT_BITS;
					rxd_out_next = sfr_req.wdata[0];
					rxd_oe_next = 1'b1;
					tx_state_next = szu_pkg::TX_SHIFT_OUT;
				end
				else if (mode == szu_pkg::SZU_MODE_SHIFT && control_reg[szu_pkg::SZU_BIT_RX_ENABLE]
					&& !control_reg[szu_pkg::SZU_BIT_RX_DONE])
				begin
					tx_left_next = szu_pkg::SZU_SHIFT_BITS;
					tx_state_next = szu_pkg::TX_SHIFT_IN;
				end
			end
			szu_pkg::TX_ASYNC:
			begin
				if (tx_end)
				begin
					tx_shift_next = {1'b1, tx_shift_reg[10:1]};
					tx_left_next = tx_left_reg - 4'h1;
					txd_next = tx_shift_reg[1];
					if (tx_left_reg == 4'h1)
					begin
						tx_done_set = 1'b1;
						txd_next = 1'b1;
						tx_state_next = szu_pkg::TX_IDLE;
					end
				end
			end
			szu_pkg::TX_SHIFT_OUT, szu_pkg::TX_SHIFT_IN:
			begin
				// clock high half then low half; bit moves on the rising edge
				rxd_oe_next = (tx_state_reg == szu_pkg::TX_SHIFT_OUT);
				div_cnt_next = sclk_tick ? 4'h0 : div_cnt_reg + 4'h1;
				sclk_next = sclk_tick ? !sclk_reg : sclk_reg;
				if (sclk_tick && !sclk_reg)
				begin
					tx_shift_next = {1'b1, tx_shift_reg[10:1]};
					rxd_out_next = tx_shift_reg[1];
					sin_next = {rxd_in, sin_reg[7:1]};
					tx_left_next = tx_left_reg - 4'h1;
				end
				if (sclk_tick && sclk_reg && tx_left_reg == 4'h0)
				begin
					sclk_next = 1'b1;
					rxd_out_next = 1'b1;
					rxd_oe_next = 1'b0;
					tx_state_next = szu_pkg::TX_IDLE;
					if (tx_state_reg == szu_pkg::TX_SHIFT_OUT)
					begin
						tx_done_set = 1'b1;
					end
					else
					begin
						rx_load = 1'b1;
						rx_load_data = sin_reg;
						rx_load_ninth = control_reg[szu_pkg::SZU_BIT_RX_NINTH];
					end
				end
				if (tx_state_reg == szu_pkg::TX_SHIFT_IN && !control_reg[szu_pkg::SZU_BIT_RX_ENABLE])
				begin
					sclk_next = 1'b1;
					tx_state_next = szu_pkg::TX_IDLE;
				end
			end
			default:
			begin
				tx_state_next = szu_pkg::TX_IDLE;
			end
		endcase
		if (wr_control)
		begin
			if (sfr_req.wdata[szu_pkg::SZU_BIT_MODE_HIGH:szu_pkg::SZU_BIT_MODE_LOW] != mode)
			begin
				// mode change abandons any transmit or shift frame in flight
				tx_state_next = szu_pkg::TX_IDLE;
				sclk_next = 1'b1;
				txd_next = 1'b1;
				rxd_oe_next = 1'b0;
			end
		end
		if (tx_state_next == szu_pkg::TX_SHIFT_OUT || tx_state_next == szu_pkg::TX_SHIFT_IN)
		begin
			txd_next = sclk_next;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_comb
	begin
		control_next = control_reg;
		rx_latch_next = rx_latch_reg;
		div_select_next = div_select_reg;
		rdata_next = 8'h00;
		rx_done_set = 1'b0;
		if (wr_control)
		begin
			control_next = sfr_req.wdata;
		end
		if (sfr_req.wr && hit(sfr_req.addr, szu_pkg::SZU_ADDR_POWER))
		begin
			div_select_next = sfr_req.wdata[szu_pkg::SZU_BIT_DIV_SELECT];
		end
		if (rx_load)
		begin
			rx_latch_next = rx_load_data;
			if (ninth_mode)
			begin
				control_next[szu_pkg::SZU_BIT_RX_NINTH] = rx_load_ninth;
			end
			// multiprocessor filter only acts in the ninth-bit mode
			rx_done_set = !(ninth_mode && control_reg[szu_pkg::SZU_BIT_MP_FILTER])
				|| rx_load_ninth;
		end
		// hardware set wins over a software clear in the same cycle
		if (tx_done_set)
		begin
			control_next[szu_pkg::SZU_BIT_TX_DONE] = 1'b1;
		end
		if (rx_done_set)
		begin
			control_next[szu_pkg::SZU_BIT_RX_DONE] = 1'b1;
		end
		if (sfr_req.rd)
		begin
			if (hit(sfr_req.addr, szu_pkg::SZU_ADDR_CONTROL))
			begin
				rdata_next = control_reg;
			end
			else if (hit(sfr_req.addr, szu_pkg::SZU_ADDR_BUFFER))
			begin
				rdata_next = rx_latch_reg;
			end
		end
	end

	assign sfr_rdata = rdata_reg;
	assign txd_out = txd_reg;
	assign rxd_out = rxd_out_reg;
	assign rxd_oe = rxd_oe_reg;
	assign serial_irq = irq_reg;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			control_reg <= szu_pkg::SZU_CONTROL_RESET;
			rx_latch_reg <= szu_pkg::SZU_BUFFER_RESET;
			div_select_reg <= 1'b0;
			rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
			tx_state_reg <= szu_pkg::TX_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			div_cnt_reg <= 4'h0;
			sclk_reg <= 1'b1;
			sin_reg <= 8'h00;
			txd_reg <= 1'b1;
			rxd_out_reg <= 1'b1;
			rxd_oe_reg <= 1'b0;
		end
		else if (ce)
		begin
			control_reg <= control_next;
			rx_latch_reg <= rx_latch_next;
			div_select_reg <= div_select_next;
			rdata_reg <= rdata_next;
			irq_reg <= control_next[szu_pkg::SZU_BIT_TX_DONE]
				|| control_next[szu_pkg::SZU_BIT_RX_DONE];
			tx_state_reg <= tx_state_next;
			tx_shift_reg <= tx_shift_next;
			tx_left_reg <= tx_left_next;
			div_cnt_reg <= div_cnt_next;
			sclk_reg <= sclk_next;
			sin_reg <= sin_next;
			txd_reg <= txd_next;
			rxd_out_reg <= rxd_out_next;
			rxd_oe_reg <= rxd_oe_next;
		end
	end
endmodule
`default_nettype wire

// ---- verif/szu_serial_port_zero_checker.sv ----
// assertions on the pins and register port of serial port zero
// assumes bound to szu_serial_port_zero, one clock domain
`timescale 1ns/1ps
`default_nettype none
module szu_serial_port_zero_checker
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire szu_pkg::szu_sfr_req_s sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	input wire logic txd_out,
	input wire logic serial_irq
);
	// ----------------------------------------
	// shadow of software-written bits
	// ----------------------------------------
	logic ctl_wr;
	logic shift_mode;
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic div_reg;
	logic div_next;
	assign ctl_wr = ce && sfr_req.wr && (sfr_req.addr == szu_pkg::SZU_ADDR_CONTROL);
	assign shift_mode = (ctl_reg[7:6] == szu_pkg::SZU_MODE_SHIFT);
	always_comb
	begin
		ctl_next = ctl_wr ? sfr_req.wdata : ctl_reg;
		div_next = div_reg;
		if (ce && sfr_req.wr && (sfr_req.addr == szu_pkg::SZU_ADDR_POWER))
			div_next = sfr_req.wdata[7];
	end
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctl_reg <= 8'h00;
			div_reg <= 1'b0;
		end
		else
		begin
			ctl_reg <= ctl_next;
			div_reg <= div_next;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_rdata_idle_zero: assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_rdata_unmapped: assert property ((ce && sfr_req.rd
		&& sfr_req.addr != szu_pkg::SZU_ADDR_CONTROL
		&& sfr_req.addr != szu_pkg::SZU_ADDR_BUFFER) |=> sfr_rdata == 8'h00)
		else $error("unmapped read returned data");
	chk_rdata_ctrl_bits: assert property ((ce && sfr_req.rd
		&& sfr_req.addr == szu_pkg::SZU_ADDR_CONTROL)
		|=> sfr_rdata[7:3] == $past(ctl_reg[7:3]))
		else $error("control read differs from written bits");
	chk_oe_shift_only: assert property (rxd_oe |-> shift_mode || $past(shift_mode))
		else $error("receive pin driven outside shift mode");
	chk_oe_first_lsb: assert property ($rose(rxd_oe) |-> rxd_out == $past(sfr_req.wdata[0]))
		else $error("first shifted bit is not the lsb");
	chk_irq_sw_clear: assert property ($fell(serial_irq)
		|-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
		else $error("interrupt dropped without a control write");
	chk_clk_low_slow: assert property (($fell(txd_out) && shift_mode && !div_reg)
		|-> !txd_out [*6] ##1 txd_out)
		else $error("slow shift clock low half not six cycles");
	chk_clk_low_fast: assert property (($fell(txd_out) && shift_mode && div_reg)
		|-> !txd_out [*2] ##1 txd_out)
		else $error("fast shift clock low half not two cycles");
endmodule
bind szu_serial_port_zero szu_serial_port_zero_checker u_chk (.sys_clk(sys_clk), .nrst(nrst),
	.ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
	.txd_out(txd_out), .serial_irq(serial_irq));
`default_nettype wire

// ---- verif/szu_far_device.sv ----
// far serial device: sends async frames, captures async and shift frames
// assumes the bench resolves the shared receive pin from all enables
`timescale 1ns/1ps
`default_nettype none
module szu_far_device
(
	input wire logic sys_clk,
	input wire logic txd_in,
	input wire logic rxd_wire,
	output logic line_drive,
	output logic line_oe
);
	initial
	begin
		line_drive = 1'b1;
		line_oe = 1'b1;
	end
	task automatic set_drive(input logic oe);
		@(posedge sys_clk);
		line_oe <= oe;
		line_drive <= 1'b1;
	endtask
	// lsb first, one bit per period
	task automatic send_async(input logic [10:0] frame, input int p);
		for (int i = 0; i < 11; i++)
		begin
			@(posedge sys_clk);
			line_drive <= frame[i];
			repeat (p - 1) @(posedge sys_clk);
		end
	endtask
	// samples at mid bit, start bit included
	task automatic catch_async(input int nbits, input int p, output logic [10:0] frame,
		output logic ok);
		int n;
		frame = 11'h000;
		n = 0;
		while (txd_in !== 1'b0 && n < 8000)
		begin
			@(negedge sys_clk);
			n++;
		end
		ok = (n < 8000);
		repeat (p / 2) @(negedge sys_clk);
		for (int i = 0; i < nbits && ok; i++)
		begin
			frame[i] = txd_in;
			repeat (p) @(negedge sys_clk);
		end
	endtask
	// data is valid in the low half, taken as the clock rises
	task automatic catch_shift(output logic [7:0] data, output logic ok);
		logic prev_clk;
		logic prev_dat;
		int n;
		int k;
		prev_clk = 1'b1;
		prev_dat = 1'b1;
		data = 8'h00;
		n = 0;
		k = 0;
		while (k < 8 && n < 1000)
		begin
			@(negedge sys_clk);
			if (txd_in === 1'b1 && prev_clk === 1'b0)
			begin
				data[k] = prev_dat;
				k++;
			end
			prev_clk = txd_in;
			prev_dat = rxd_wire;
			n++;
		end
		ok = (k == 8);
	endtask
	// drives the receive pin; next bit after each rising shift clock
	task automatic send_shift(input logic [7:0] data, output logic ok);
		logic prev_clk;
		int n;
		int k;
		prev_clk = 1'b1;
		n = 0;
		k = 0;
		@(posedge sys_clk);
		line_oe <= 1'b1;
		line_drive <= data[0];
		while (k < 8 && n < 1000)
		begin
			@(posedge sys_clk);
			if (txd_in === 1'b1 && prev_clk === 1'b0)
			begin
				k++;
				if (k < 8)
				begin
					line_drive <= data[k];
				end
				else
				begin
					line_drive <= 1'b1;
				end
			end
			prev_clk = txd_in;
			n++;
		end
		ok = (k == 8);
	endtask
endmodule
`default_nettype wire

// ---- verif/szu_serial_port_zero_tb_top.sv ----
// self-checking bench for serial port zero
// assumes the checker is bound and the far device model is compiled
`timescale 1ns/1ps
`default_nettype none
module szu_serial_port_zero_tb_top;
	logic sys_clk;
	logic nrst;
	logic ce;
	szu_pkg::szu_sfr_req_s sfr_req;
	logic [7:0] sfr_rdata;
	logic [15:0] t1;
	logic [15:0] t2;
	logic run1;
	logic txs;
	logic rxs;
	logic rxd_wire;
	logic rxd_out;
	logic rxd_oe;
	logic txd_out;
	logic irq;
	logic far_drive;
	logic far_oe;
	int fails;
	int n_checks;
	// pull-up on the shared receive pin
	assign rxd_wire = rxd_oe ? rxd_out : (far_oe ? far_drive : 1'b1);
	szu_serial_port_zero dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .timer_one_reload(t1), .timer_two_reload(t2),
		.timer_one_run(run1), .tx_timer_two_clock_select(txs), .rx_timer_two_clock_select(rxs),
		.rxd_in(rxd_wire), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
		.serial_irq(irq));
	szu_far_device u_far (.sys_clk(sys_clk), .txd_in(txd_out), .rxd_wire(rxd_wire),
		.line_drive(far_drive), .line_oe(far_oe));
	always #2.5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge sys_clk);
		sfr_req.wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge sys_clk);
		sfr_req.rd <= 1'b0;
		@(negedge sys_clk);
		d = sfr_rdata;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [7:0] v;
		rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
		check("control reset", szu_pkg::SZU_CONTROL_RESET, v);
		rd_reg(szu_pkg::SZU_ADDR_BUFFER, v);
		check("buffer reset", szu_pkg::SZU_BUFFER_RESET, v);
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'hd8);
		rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
		check("control rw", 8'hd8, v);
		rd_reg(szu_pkg::SZU_ADDR_POWER, v);
		check("power read", 8'h00, v);
		rd_reg(8'h55, v);
		check("unmapped read", 8'h00, v);
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_async_tx;
		logic [7:0] c;
		logic [7:0] v;
		logic [10:0] f;
		logic ok;
		for (int i = 0; i < 3; i++)
		begin
			c = (i == 1) ? 8'hc8 : 8'h40;
			wr_reg(szu_pkg::SZU_ADDR_POWER, (i == 2) ? 8'h80 : 8'h00);
			txs <= (i == 1);
			wr_reg(szu_pkg::SZU_ADDR_CONTROL, c);
			wr_reg(szu_pkg::SZU_ADDR_BUFFER, 8'ha5);
			u_far.catch_async((i == 1) ? 11 : 10,
				(i == 2) ? 256 : ((i == 1) ? 24 : 16), f, ok);
			check("async tx done", 11'h001, {10'h000, ok});
			if (!ok)
				test_done();
			check("async frame", (i == 1) ? 11'h74a : 11'h34a, f);
			repeat (40) @(posedge sys_clk);
			rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
			check("tx flag", c | 8'h02, v);
			check("irq set", 11'h001, {10'h000, irq});
			wr_reg(szu_pkg::SZU_ADDR_CONTROL, c);
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			check("irq cleared", 11'h000, {10'h000, irq});
		end
	endtask
	task automatic t_async_rx;
		logic [8:0] fr [4] = '{9'h181, 9'h03c, 9'h1c3, 9'h15a};
		logic [7:0] cw [4] = '{8'h70, 8'hf0, 8'hf0, 8'he0};
		logic [7:0] ec [4] = '{8'h71, 8'hf0, 8'hf5, 8'he0};
		logic [7:0] eb [4] = '{8'h81, 8'h3c, 8'hc3, 8'hc3};
		logic [7:0] v;
		@(posedge sys_clk);
		rxs <= 1'b1;
		wr_reg(szu_pkg::SZU_ADDR_POWER, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(szu_pkg::SZU_ADDR_CONTROL, cw[i]);
			u_far.send_async({1'b1, fr[i], 1'b0}, 24);
			repeat (4) @(posedge sys_clk);
			rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
			check("rx control", ec[i], v);
			rd_reg(szu_pkg::SZU_ADDR_BUFFER, v);
			check("rx latch", eb[i], v);
		end
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_shift_tx(input logic d);
		logic [7:0] v;
		logic ok;
		u_far.set_drive(1'b0);
		wr_reg(szu_pkg::SZU_ADDR_POWER, {d, 7'h00});
		wr_reg(szu_pkg::SZU_ADDR_BUFFER, 8'h96);
		u_far.catch_shift(v, ok);
		check("shift done", 11'h001, {10'h000, ok});
		if (!ok)
			test_done();
		check("shift data", 8'h96, v);
		repeat (8) @(posedge sys_clk);
		rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
		check("shift flag", 8'h02, v);
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'h00);
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'h10);
		u_far.send_shift(d ? 8'h3a : 8'h5b, ok);
		check("shift rx done", 11'h001, {10'h000, ok});
		repeat (8) @(posedge sys_clk);
		rd_reg(szu_pkg::SZU_ADDR_CONTROL, v);
		check("shift rx flag", 8'h11, v);
		rd_reg(szu_pkg::SZU_ADDR_BUFFER, v);
		check("shift rx data", d ? 8'h3a : 8'h5b, v);
		wr_reg(szu_pkg::SZU_ADDR_CONTROL, 8'h00);
		u_far.set_drive(1'b1);
	endtask
	initial
	begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		sfr_req = '0;
		t1 = 16'h0010;
		t2 = 16'h0018;
		run1 = 1'b0;
		txs = 1'b0;
		rxs = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_async_tx();
		t_async_rx();
		t_shift_tx(1'b0);
		t_shift_tx(1'b1);
		test_done();
	end
endmodule
`default_nettype wire
